//--- common/fcc_consts.vh
/*
  Constants for the field codec encode control block: register offsets, field
  positions, reset values and timing counts. Assumes a 125 MHz system clock.
*/
`ifndef FCC_CONSTS_VH
`define FCC_CONSTS_VH

`define FCC_ADDR_W          4
`define FCC_REG_CTRL        4'h0
`define FCC_REG_SKIP        4'h1
`define FCC_REG_BOX_X       4'h2
`define FCC_REG_BOX_Y       4'h3
`define FCC_REG_CONTRAST    4'h4
`define FCC_REG_STATUS      4'h5
`define FCC_REG_FIELD_SIZE  4'h6
`define FCC_REG_FIFO_DATA   4'h7
`define FCC_REG_FIFO_LEVEL  4'h8

`define FCC_CTRL_ENC_BIT    0
`define FCC_CTRL_WIDE_BIT   1
`define FCC_CTRL_RESET      2'h0
`define FCC_SKIP_W          5
`define FCC_CONTRAST_W      8
`define FCC_CONTRAST_RESET  8'hFF
`define FCC_MAX_WIDTH       720
`define FCC_MAX_LINES       288
`define FCC_POS_W           10
`define FCC_FIFO_DEPTH      512
`define FCC_FIFO_AW         9
`define FCC_PIX_MHZ_X100    1350
`define FCC_CLK_MHZ_X100    12500
`define FCC_PIX_MIN_CYC     ((`FCC_CLK_MHZ_X100 + `FCC_PIX_MHZ_X100 - 1) / `FCC_PIX_MHZ_X100)

`endif

//--- rtl/fcc_encode_control.v
/*
  Encode-side control and framing around a field codec: interlaced field intake,
  field skipping, stall, quality box contrast, compressed FIFO and Avalon-MM slave.
  Assumes video inputs, stall and bus signals are synchronous to clk.
*/
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`default_nettype none
`include "fcc_consts.vh"
module fcc_encode_control #(
  parameter FIFO_DEPTH = `FCC_FIFO_DEPTH,
  parameter FIFO_AW    = `FCC_FIFO_AW,
  parameter MAX_WIDTH  = `FCC_MAX_WIDTH,
  parameter MAX_LINES  = `FCC_MAX_LINES
) (
  input  wire                     clk,
  input  wire                     sys_rst,
  // video port
  input  wire [7:0]               vid_data,
  input  wire                     vid_valid,
  input  wire                     vid_field_start,
  input  wire                     vid_line_start,
  input  wire                     stall,
  // toward coder core: weighted pixel stream
  output reg  [7:0]               pix_data,
  output reg  [7:0]               pix_contrast,
  output reg                      pix_valid,
  output reg                      pix_field_start,
  // coder core to FIFO (encode direction)
  input  wire [31:0]              enc_word,
  input  wire                     enc_word_valid,
  input  wire                     enc_field_end,
  output wire                     enc_word_ready,
  // FIFO to coder core (decode direction)
  output reg  [31:0]              dec_word,
  output reg                      dec_word_valid,
  input  wire                     dec_word_ready,
  // mode and status pins
  output wire                     encode_mode,
  output wire                     halted,
  // Avalon-MM slave
  input  wire [`FCC_ADDR_W-1:0]   avs_address,
  input  wire                     avs_read,
  input  wire                     avs_write,
  input  wire [31:0]              avs_writedata,
  input  wire [3:0]               avs_byteenable,
  output reg  [31:0]              avs_readdata,
  output wire                     avs_waitrequest
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  function [31:0] fcc_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer k;
    begin
      fcc_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k])
          fcc_merge[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
  endfunction

  function in_span;
    input [`FCC_POS_W-1:0] p;
    input [`FCC_POS_W-1:0] lo;
    input [`FCC_POS_W-1:0] hi;
    begin
      in_span = (p >= lo) && (p <= hi);
    end
  endfunction

  // registers
  reg [1:0]                 ctrl_q;
  reg [`FCC_SKIP_W-1:0]     skip_q;
  reg [2*`FCC_POS_W-1:0]    box_x_q;
  reg [2*`FCC_POS_W-1:0]    box_y_q;
  reg [`FCC_CONTRAST_W-1:0] contrast_q;
  reg [31:0]                field_size_q;
  reg                       size_valid_q;
  reg [1:0]                 ack_q;
  reg                       stall_q;

  assign encode_mode = ctrl_q[`FCC_CTRL_ENC_BIT];
  // one-cycle registered answer: waitrequest is high until the answer cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q[1];

  // stall registered: in encode mode only, halts on the clock after the pin rises
  always @(posedge clk) begin
    if (sys_rst)
      stall_q <= 1'b0;
    else
      stall_q <= stall & encode_mode;
  end
  assign halted = stall_q;

  // field intake, skipping, geometry limits
  reg [`FCC_POS_W-1:0]  col_q;
  reg [`FCC_POS_W-1:0]  row_q;
  reg [`FCC_SKIP_W-1:0] skip_cnt_q;
  reg                   field_keep_q;
  reg                   in_field_q;

  // the source must not present pixels faster than the pixel rate limit;
  // no buffering is kept on the video side, so a held pixel waits on the pin
  wire take_pix = vid_valid & ~stall_q & encode_mode;

  wire [`FCC_POS_W-1:0] bx_lo = box_x_q[`FCC_POS_W-1:0];
  wire [`FCC_POS_W-1:0] bx_hi = box_x_q[2*`FCC_POS_W-1:`FCC_POS_W];
  wire [`FCC_POS_W-1:0] by_lo = box_y_q[`FCC_POS_W-1:0];
  wire [`FCC_POS_W-1:0] by_hi = box_y_q[2*`FCC_POS_W-1:`FCC_POS_W];
  wire in_box = in_span(col_q, bx_lo, bx_hi) & in_span(row_q, by_lo, by_hi);
  wire in_active = (col_q < MAX_WIDTH[`FCC_POS_W-1:0]) &&
                   (row_q < MAX_LINES[`FCC_POS_W-1:0]);

  always @(posedge clk) begin
    if (sys_rst) begin
      col_q           <= {`FCC_POS_W{1'b0}};
      row_q           <= {`FCC_POS_W{1'b0}};
      skip_cnt_q      <= {`FCC_SKIP_W{1'b0}};
      field_keep_q    <= 1'b0;
      in_field_q      <= 1'b0;
      pix_data        <= 8'h00;
      pix_contrast    <= 8'h00;
      pix_valid       <= 1'b0;
      pix_field_start <= 1'b0;
    end else if (stall_q) begin
      // hold every position, pix_data and pix_contrast while halted; pix_valid and pix_field_start drop to 0
      pix_valid       <= 1'b0;
      pix_field_start <= 1'b0;
    end else begin
      pix_valid       <= 1'b0;
      pix_field_start <= 1'b0;
      if (take_pix) begin
        if (vid_field_start) begin
          // each field starts from clean column and row counters, no carry between fields
          col_q      <= {`FCC_POS_W{1'b0}};
          row_q      <= {`FCC_POS_W{1'b0}};
          in_field_q <= 1'b1;
          if (skip_cnt_q == {`FCC_SKIP_W{1'b0}}) begin
            field_keep_q <= 1'b1;
            skip_cnt_q   <= skip_q;
          end else begin
            field_keep_q <= 1'b0;
            skip_cnt_q   <= skip_cnt_q - 1'b1;
          end
        end else if (vid_line_start) begin
          col_q <= {`FCC_POS_W{1'b0}};
          if (row_q != {`FCC_POS_W{1'b1}})
            row_q <= row_q + 1'b1;
        end else if (col_q != {`FCC_POS_W{1'b1}}) begin
          col_q <= col_q + 1'b1;
        end
        if (!vid_field_start && !vid_line_start && in_field_q && field_keep_q && in_active) begin
          pix_data     <= vid_data;
          pix_contrast <= in_box ? `FCC_CONTRAST_RESET : contrast_q;
          pix_valid    <= 1'b1;
        end
        if (vid_field_start && skip_cnt_q == {`FCC_SKIP_W{1'b0}})
          pix_field_start <= 1'b1;
      end
      if (!encode_mode) begin
        skip_cnt_q <= {`FCC_SKIP_W{1'b0}};
        in_field_q <= 1'b0;
      end
    end
  end

  // compressed FIFO, 512 x 32, one store shared by both directions
  reg [31:0]        mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW:0]   wr_ptr_q;
  reg [FIFO_AW:0]   rd_ptr_q;
  reg [FIFO_AW:0]   fields_in_fifo_q;
  reg [31:0]        bytes_cnt_q;
  reg               half_q;
  reg [15:0]        half_lo_q;
  reg [1:0]         dec_st_q;

  wire [FIFO_AW:0] level = wr_ptr_q - rd_ptr_q;
  wire fifo_full  = level == FIFO_DEPTH[FIFO_AW:0];
  wire fifo_empty = level == {(FIFO_AW+1){1'b0}};
  wire wide       = ctrl_q[`FCC_CTRL_WIDE_BIT];

  wire bus_do     = (avs_read | avs_write) & ~ack_q[1] & ~ack_q[0];
  wire host_wr    = bus_do & avs_write & (avs_address == `FCC_REG_FIFO_DATA);
  wire host_rd    = bus_do & avs_read & (avs_address == `FCC_REG_FIFO_DATA);

  // in 16-bit mode two halves pair into one word, low half first
  wire host_push  = host_wr & ~encode_mode & ~fifo_full & (wide | half_q);
  wire host_pop   = host_rd & encode_mode & ~fifo_empty & (wide | half_q);

  assign enc_word_ready = encode_mode & ~fifo_full;
  wire enc_push  = enc_word_valid & enc_word_ready;
  wire dec_pop   = ~encode_mode & ~fifo_empty & (~dec_word_valid | dec_word_ready);
  wire do_push   = enc_push | host_push;
  wire do_pop    = host_pop | dec_pop;
  wire [31:0] push_word = encode_mode ? enc_word :
                          (wide ? avs_writedata : {avs_writedata[15:0], half_lo_q});
  wire [31:0] head = mem[rd_ptr_q[FIFO_AW-1:0]];

  always @(posedge clk) begin
    if (do_push)
      mem[wr_ptr_q[FIFO_AW-1:0]] <= push_word;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q         <= {(FIFO_AW+1){1'b0}};
      rd_ptr_q         <= {(FIFO_AW+1){1'b0}};
      half_q           <= 1'b0;
      half_lo_q        <= 16'h0000;
      dec_word         <= 32'h0000_0000;
      dec_word_valid   <= 1'b0;
      fields_in_fifo_q <= {(FIFO_AW+1){1'b0}};
      bytes_cnt_q      <= 32'h0000_0000;
      field_size_q     <= 32'h0000_0000;
      size_valid_q     <= 1'b0;
      dec_st_q         <= ST_IDLE;
    end else begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (!wide && ((host_wr && !encode_mode && !fifo_full) ||
                    (host_rd && encode_mode && !fifo_empty))) begin
        half_q <= ~half_q;
        if (!half_q)
          half_lo_q <= avs_writedata[15:0];
      end
      if (dec_pop) begin
        dec_word       <= head;
        dec_word_valid <= 1'b1;
      end else if (dec_word_ready) begin
        dec_word_valid <= 1'b0;
      end
      // field size count, reported after the end-of-field marker word
      if (enc_push) begin
        if (enc_field_end) begin
          field_size_q <= bytes_cnt_q + 32'h0000_0004;
          bytes_cnt_q  <= 32'h0000_0000;
        end else begin
          bytes_cnt_q <= bytes_cnt_q + 32'h0000_0004;
        end
      end
      // fields whose end marker still sits in the FIFO: a second whole field there
      // means the drain side has not started, so the size is not yet valid
      if ((enc_push & enc_field_end) && !(host_pop & fields_in_fifo_q != 0 & fifo_empty))
        fields_in_fifo_q <= fields_in_fifo_q + 1'b1;
      else if (host_pop && level == 1 && fields_in_fifo_q != 0)
        fields_in_fifo_q <= {(FIFO_AW+1){1'b0}};
      case (dec_st_q)
        ST_IDLE: begin
          if (enc_push & enc_field_end)
            dec_st_q <= ST_DONE;
        end
        ST_DONE: begin
          dec_st_q <= ST_IDLE;
        end
        default: dec_st_q <= ST_IDLE;
      endcase
      size_valid_q <= (dec_st_q == ST_DONE || size_valid_q) &&
                      (fields_in_fifo_q < 2) && !(enc_push & enc_field_end & ~size_valid_q);
      if (!encode_mode)
        size_valid_q <= 1'b0;
    end
  end

  // byte-lane merge of a control write, only the two low bits are kept
  wire [31:0] ctrl_merged = fcc_merge({30'h0, ctrl_q}, avs_writedata, avs_byteenable);

  // register file; control, skip, box and contrast are written by the host,
  // while status, field size and FIFO level are read-only here
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q       <= `FCC_CTRL_RESET;
      skip_q       <= {`FCC_SKIP_W{1'b0}};
      box_x_q      <= {2*`FCC_POS_W{1'b0}};
      box_y_q      <= {2*`FCC_POS_W{1'b0}};
      contrast_q   <= `FCC_CONTRAST_RESET;
      ack_q        <= 2'b00;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= {bus_do, 1'b0};
      if (bus_do && avs_write) begin
        case (avs_address)
          `FCC_REG_CTRL:     ctrl_q <= ctrl_merged[1:0];
          `FCC_REG_SKIP:     skip_q <= avs_writedata[`FCC_SKIP_W-1:0];
          `FCC_REG_BOX_X:    box_x_q <= avs_writedata[2*`FCC_POS_W-1:0];
          `FCC_REG_BOX_Y:    box_y_q <= avs_writedata[2*`FCC_POS_W-1:0];
          `FCC_REG_CONTRAST: contrast_q <= avs_writedata[`FCC_CONTRAST_W-1:0];
          default: ;
        endcase
      end
      if (bus_do && avs_read) begin
        case (avs_address)
          `FCC_REG_CTRL:       avs_readdata <= {30'h0, ctrl_q};
          `FCC_REG_SKIP:       avs_readdata <= {27'h0, skip_q};
          `FCC_REG_BOX_X:      avs_readdata <= {12'h0, box_x_q};
          `FCC_REG_BOX_Y:      avs_readdata <= {12'h0, box_y_q};
          `FCC_REG_CONTRAST:   avs_readdata <= {24'h0, contrast_q};
          `FCC_REG_STATUS:     avs_readdata <= {27'h0, size_valid_q, stall_q,
                                                fifo_full, fifo_empty, encode_mode};
          `FCC_REG_FIELD_SIZE: avs_readdata <= field_size_q;
          `FCC_REG_FIFO_DATA:  avs_readdata <= wide ? head :
                                               (half_q ? {16'h0, head[31:16]}
                                                       : {16'h0, head[15:0]});
          `FCC_REG_FIFO_LEVEL: avs_readdata <= {{(31-FIFO_AW){1'b0}}, level};
          default:             avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- sim/fcc_core_model.sv
/* coder-core stand-in: pushes one field of words toward the FIFO and sinks
   decoded words; assumes the valid/ready handshake of the block */
`default_nettype none
module fcc_core_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic [9:0]  n_words,
  input  wire logic        enc_word_ready,
  output var  logic [31:0] enc_word,
  output var  logic        enc_word_valid,
  output var  logic        enc_field_end,
  output var  logic        dec_word_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] left_q, idx_q, i, l;
  logic       v;
  initial {enc_word, enc_word_valid, enc_field_end, dec_word_ready} = 35'h0;
  always @(posedge clk) begin
    dec_word_ready <= ($urandom % 3) != 0;
    if (sys_rst || go) begin
      left_q <= sys_rst ? 10'h0 : n_words;
      idx_q <= 10'h0;
      enc_word_valid <= 1'b0;
      enc_field_end <= 1'b0;
    end else if (!enc_word_valid || enc_word_ready) begin
      // a raised word is held until taken, so gaps come only between words
      i = idx_q + {9'h0, enc_word_valid};
      l = left_q - {9'h0, enc_word_valid};
      v = (l != 10'h0) && (($urandom % 4) != 0);
      idx_q <= i;
      left_q <= l;
      enc_word_valid <= v;
      enc_field_end <= v && (l == 10'h1);
      enc_word <= v ? {16'hA5A5 ^ {6'h0, i}, 6'h0, i} : ~enc_word;
    end
  end
endmodule
`default_nettype wire

//--- sim/fcc_encode_control_assertions.sv
/* port-level checks for fcc_encode_control
   assumes one clock domain and a synchronous active-high sys_rst */
`default_nettype none
module fcc_encode_control_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        vid_valid,
  input wire logic        vid_field_start,
  input wire logic        stall,
  input wire logic        pix_valid,
  input wire logic        pix_field_start,
  input wire logic        enc_word_ready,
  input wire logic [31:0] dec_word,
  input wire logic        dec_word_valid,
  input wire logic        dec_word_ready,
  input wire logic        encode_mode,
  input wire logic        halted,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_acked;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  a_halt_next: assert property (stall && encode_mode |=> halted)
    else $error("halt did not follow stall");
  a_halt_ends: assert property (!stall |=> !halted)
    else $error("halt outlived stall");
  a_halt_blocks: assert property (halted |=> !pix_valid)
    else $error("pixel passed while halted");
  a_pix_cause: assert property (pix_valid |-> $past(vid_valid && !halted && encode_mode))
    else $error("pixel without accepted input");
  a_field_cause: assert property (pix_field_start |-> $past(vid_valid && vid_field_start))
    else $error("field start without input marker");
  a_ready_mode: assert property (enc_word_ready |-> encode_mode)
    else $error("coder words accepted outside encode");
  a_one_wait: assert property (s_taken |=> !avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_b2b_wait: assert property (s_acked ##1 (avs_read || avs_write) |-> avs_waitrequest)
    else $error("back-to-back request not waited");
  a_rd_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_dec_hold: assert property (dec_word_valid && !dec_word_ready |=> dec_word_valid && $stable(dec_word))
    else $error("decode word dropped while stalled");
endmodule
`default_nettype wire

//--- sim/tb.sv
/* self-checking bench for fcc_encode_control: bus tasks, video driver, monitors
   assumes fcc_core_model on the coder side and the checker bound at the foot */
`default_nettype none
`include "fcc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, vid_valid, vid_field_start, vid_line_start, stall, go, stall_en;
  logic        pix_valid, pix_field_start, enc_word_valid, enc_field_end, enc_word_ready, b2b;
  logic        dec_word_valid, dec_word_ready, encode_mode, halted;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] enc_word, dec_word, avs_writedata, avs_readdata, w;
  logic [3:0]  avs_address;
  logic [9:0]  n_words, x, blo, bhi;
  logic [7:0]  vid_data, pix_data, pix_contrast, con;
  logic [15:0] exp_q[$];
  logic [31:0] dec_q[$];
  int          error_cnt, samples_checked, fs_cnt, k, s;
  fcc_encode_control u_dut (.clk(clk), .sys_rst(sys_rst), .vid_data(vid_data),
    .vid_valid(vid_valid), .vid_field_start(vid_field_start), .vid_line_start(vid_line_start),
    .stall(stall), .pix_data(pix_data), .pix_contrast(pix_contrast), .pix_valid(pix_valid),
    .pix_field_start(pix_field_start), .enc_word(enc_word), .enc_word_valid(enc_word_valid),
    .enc_field_end(enc_field_end), .enc_word_ready(enc_word_ready), .dec_word(dec_word),
    .dec_word_valid(dec_word_valid), .dec_word_ready(dec_word_ready),
    .encode_mode(encode_mode), .halted(halted), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fcc_core_model u_core (.clk(clk), .sys_rst(sys_rst), .go(go), .n_words(n_words),
    .enc_word_ready(enc_word_ready), .enc_word(enc_word), .enc_word_valid(enc_word_valid),
    .enc_field_end(enc_field_end), .dec_word_ready(dec_word_ready));
  function automatic logic [31:0] ew(input int i);
    return {16'hA5A5 ^ i[15:0], i[15:0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // b2b leaves the request up so the next call follows without an idle cycle
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    w = avs_readdata;
    if (!b2b) begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(w, exp);
  endtask
  task vcyc(input logic fs, input logic ls, input logic [7:0] d, input logic keep);
    vid_valid <= 1'b1;
    vid_field_start <= fs;
    vid_line_start <= ls;
    vid_data <= d;
    stall <= stall_en && ($urandom % 4 == 0);
    @(posedge clk);
    while (halted !== 1'b0) begin
      stall <= stall_en && ($urandom % 3 == 0);
      @(posedge clk);
    end
    if (keep && !fs && !ls) exp_q.push_back({d, (x >= blo && x <= bhi) ? 8'hFF : con});
    if (ls) x = 10'h0;
    else if (!fs) x++;
    vid_valid <= 1'b0;
    repeat (`FCC_PIX_MIN_CYC - 1) @(posedge clk);
  endtask
  task field(input logic keep, input int lines);
    vcyc(1'b1, 1'b0, 8'h0, keep);
    for (int l = 0; l < lines; l++) begin
      vcyc(1'b0, 1'b1, 8'h0, keep);
      for (int p = 0; p < 16; p++) vcyc(1'b0, 1'b0, 8'($urandom), keep);
    end
    stall <= 1'b0;
    @(posedge clk);
  endtask
  task final_report;
    $display("Counts: %0d checked, %0d mismatches", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (pix_valid === 1'b1) chk({pix_data, pix_contrast}, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
    if (pix_field_start === 1'b1) fs_cnt++;
    if (dec_word_valid === 1'b1 && dec_word_ready === 1'b1) chk(dec_word, dec_q.size() ? dec_q.pop_front() : 32'hXXXX_XXXX);
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {vid_valid, vid_field_start, vid_line_start, stall, go, stall_en, b2b, avs_read} = 8'h0;
    {avs_write, vid_data, avs_address, avs_writedata, n_words, x, blo, bhi, con} = 85'h0;
    sys_rst = 1'b1;
    void'($urandom(32'hFA2CD999));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rdc(4'hF, 32'h0);
    rdc(`FCC_REG_CONTRAST, 32'hFF);
    rdc(`FCC_REG_STATUS, 32'h2);
    bus(1'b1, `FCC_REG_FIELD_SIZE, 32'h1234_5678);
    rdc(`FCC_REG_FIELD_SIZE, 32'h0);
    k = $urandom;
    bus(1'b1, `FCC_REG_SKIP, k);
    rdc(`FCC_REG_SKIP, k & 32'h1F);
    $display("done: registers");
    bus(1'b1, `FCC_REG_SKIP, 32'h0);
    bus(1'b1, `FCC_REG_CTRL, 32'h3);
    blo = 10'($urandom % 8);
    bhi = blo + 10'($urandom % 8);
    con = 8'($urandom);
    bus(1'b1, `FCC_REG_BOX_X, {12'h0, bhi, blo});
    bus(1'b1, `FCC_REG_BOX_Y, {12'h0, 10'h11F, 10'h0});
    bus(1'b1, `FCC_REG_CONTRAST, {24'h0, con});
    stall_en = 1'b1;
    field(1'b1, 2);
    stall_en = 1'b0;
    chk(exp_q.size(), 32'h0);
    chk(fs_cnt, 32'h1);
    $display("done: box and stall");
    for (int r = 0; r < 2; r++) begin
      s = r ? 31 : 1 + $urandom % 30;
      fs_cnt = 0;
      bus(1'b1, `FCC_REG_SKIP, s);
      for (int f = 0; f < 2 * (s + 1); f++) field(f == 0 || f == s + 1, 1);
      chk(fs_cnt, 32'h2);
    end
    bus(1'b1, `FCC_REG_CTRL, 32'h0);
    field(1'b0, 1);
    chk(fs_cnt, 32'h2);
    chk(exp_q.size(), 32'h0);
    $display("done: skipping");
    bus(1'b1, `FCC_REG_CTRL, 32'h1);
    n_words <= 10'd520;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 3000 && enc_word_ready !== 1'b0; k++) @(posedge clk);
    rdc(`FCC_REG_FIFO_LEVEL, 32'h200);
    rdc(`FCC_REG_STATUS, 32'h5);
    b2b = 1'b1;
    // narrow host port: low half of each word first
    for (k = 0; k < 520; k++) begin
      rdc(`FCC_REG_FIFO_DATA, ew(k) & 32'hFFFF);
      rdc(`FCC_REG_FIFO_DATA, ew(k) >> 16);
    end
    b2b = 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    rdc(`FCC_REG_FIFO_LEVEL, 32'h0);
    rdc(`FCC_REG_FIELD_SIZE, 32'h820);
    rdc(`FCC_REG_STATUS, 32'h13);
    $display("done: encode fifo");
    bus(1'b1, `FCC_REG_CTRL, 32'h2);
    for (int q = 0; q < 4; q++) begin
      k = $urandom;
      dec_q.push_back(k);
      bus(1'b1, `FCC_REG_FIFO_DATA, k);
    end
    for (k = 0; k < 200 && dec_q.size() > 0; k++) @(posedge clk);
    chk(dec_q.size(), 32'h0);
    $display("done: decode fifo");
    final_report();
  end
endmodule
bind fcc_encode_control fcc_encode_control_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .vid_valid(vid_valid), .vid_field_start(vid_field_start), .stall(stall),
  .pix_valid(pix_valid), .pix_field_start(pix_field_start), .enc_word_ready(enc_word_ready),
  .dec_word(dec_word), .dec_word_valid(dec_word_valid), .dec_word_ready(dec_word_ready),
  .encode_mode(encode_mode), .halted(halted), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
